/* ppc_ctrl.sv */
// pulse generator control: apb registers, 10-bit timing counter, pulse output
// ***************************************************
// ***************************************************
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module ppc_ctrl (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // comparator levels, asynchronous
  input  wire logic        comparator_one,
  input  wire logic        comparator_two,
  input  wire logic        comparator_three,
  input  wire logic        comparator_four,
  input  wire logic        comparator_five,
  input  wire logic        comparator_six,
  input  wire logic        comparator_seven,
  input  wire logic        comparator_eight,
  // beeper, same clock
  input  wire logic        beeper_in,
  // pins and analog controls
  output logic             pulse_output_pin,
  output logic             pulse_output_oe_n,
  output logic             port_thirty_out,
  output logic       [1:0] comparator_six_ref,
  output logic       [1:0] amp_two_gain,
  output logic             irq_004b
);

  // ***************************************************
  // comparator synchronisation and edges
  // ***************************************************
  logic [7:0] cmp_s;
  logic [7:0] cmp_prev_q;

  ppc_sync #(.W(ppc_pkg::cmp_w)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({comparator_eight, comparator_seven, comparator_six, comparator_five,
                comparator_four, comparator_three, comparator_two, comparator_one}),
    .sync_out (cmp_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_prev_q <= 8'h00;
    end else begin
      cmp_prev_q <= cmp_s;
    end
  end

  logic [7:0] cmp_fall;
  logic [7:0] cmp_rise;
  assign cmp_fall = cmp_prev_q & ~cmp_s;
  assign cmp_rise = cmp_s & ~cmp_prev_q;

  // ***************************************************
  // register state
  // ***************************************************
  logic       drive_en_q, run_q, run_prev_q, mode_q, mode_act_q, surge_detect_enable_q, sel_q;
  logic       history_q, comparator_two_seen_q, surge_flag_q, surge_ien_q;
  logic [1:0] ref_q, gain_q;
  logic       c6_req_q, c6_ien_q, gate_q, src_q;
  logic [9:0] start_val_q, end_a_q, end_b_q;

  // ***************************************************
  // apb slave: one wait state, answer on second access cycle
  // ***************************************************
  logic        access, hit, wr;
  logic [15:0] idx;
  logic [7:0]  rd_byte;
  logic [7:0]  wd;

  assign access = psel & penable;
  assign idx    = paddr[17:2];
  assign wd     = pwdata[7:0];
  assign hit    = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'h0) &&
                  (idx >= ppc_pkg::idx_control_one) && (idx <= ppc_pkg::idx_end_b_high);
  assign wr     = access & pready & pwrite & hit;

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      ppc_pkg::idx_control_one: rd_byte = {drive_en_q, run_q, mode_q, surge_detect_enable_q, sel_q,
                                           history_q, surge_flag_q, surge_ien_q};
      ppc_pkg::idx_control_two: rd_byte = {ref_q, c6_req_q, c6_ien_q, gate_q, src_q, gain_q};
      ppc_pkg::idx_start_low:   rd_byte = start_val_q[7:0];
      ppc_pkg::idx_start_high:  rd_byte = {ppc_pkg::high_byte_fill, start_val_q[9:8]};
      ppc_pkg::idx_end_a_low:   rd_byte = end_a_q[7:0];
      ppc_pkg::idx_end_a_high:  rd_byte = {ppc_pkg::high_byte_fill, end_a_q[9:8]};
      ppc_pkg::idx_end_b_low:   rd_byte = end_b_q[7:0];
      ppc_pkg::idx_end_b_high:  rd_byte = {ppc_pkg::high_byte_fill, end_b_q[9:8]};
      default:                  rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      if (access & ~pready) begin
        pslverr <= ~hit;
        prdata  <= (hit & ~pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  logic w_cr1, w_cr2;
  assign w_cr1 = wr && (idx == ppc_pkg::idx_control_one);
  assign w_cr2 = wr && (idx == ppc_pkg::idx_control_two);

  // ***************************************************
  // event qualification
  // ***************************************************
  logic surge_ev, run_rise, sync, comparator_two_ev;

  assign surge_ev = surge_detect_enable_q & (|(cmp_rise & 8'hb8));
  assign comparator_two_ev  = drive_en_q & cmp_rise[ppc_pkg::c_two];
  assign run_rise = run_q & ~run_prev_q;
  // run rise starts a period in both modes
  // comparator-one fall also resyncs in mode one
  assign sync     = run_rise | (run_q & mode_act_q & cmp_fall[ppc_pkg::c_one]);

  // ***************************************************
  // control one
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_en_q  <= 1'b0;
      run_q       <= 1'b0;
      run_prev_q  <= 1'b0;
      mode_q      <= 1'b0;
      surge_detect_enable_q     <= 1'b0;
      surge_ien_q <= 1'b0;
    end else begin
      run_prev_q <= run_q;
      if (w_cr1) begin
        drive_en_q  <= wd[ppc_pkg::pos_pin_drive_enable];
        surge_detect_enable_q     <= wd[ppc_pkg::pos_surge_detect_enable];
        surge_ien_q <= wd[ppc_pkg::pos_surge_interrupt_enable];
        if (!(run_q && wd[ppc_pkg::pos_output_run])) begin
          mode_q <= wd[ppc_pkg::pos_resync_mode];
        end
      end
      // surge stop beats a software run write
      if (surge_ev && drive_en_q) begin
        run_q <= 1'b0;
      end else if (w_cr1) begin
        run_q <= wd[ppc_pkg::pos_output_run];
      end
    end
  end

  // active mode sampled only at run rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_act_q <= 1'b0;
    end else if (run_rise) begin
      mode_act_q <= mode_q;
    end
  end

  // hardware-set flags: set wins over a clearing write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q        <= 1'b0;
      surge_flag_q <= 1'b0;
      c6_req_q     <= 1'b0;
    end else begin
      if (comparator_two_ev) begin
        sel_q <= 1'b1;
      end else if (w_cr1) begin
        sel_q <= wd[ppc_pkg::pos_end_set_select];
      end
      // sticky surge flag, cleared by writing zero
      if (surge_ev && drive_en_q) begin
        surge_flag_q <= 1'b1;
      end else if (w_cr1 && !wd[ppc_pkg::pos_surge_flag]) begin
        surge_flag_q <= 1'b0;
      end
      // comparator-six fall request, cleared by writing zero
      if (drive_en_q && cmp_fall[ppc_pkg::c_six]) begin
        c6_req_q <= 1'b1;
      end else if (w_cr2 && !wd[ppc_pkg::pos_comparator_six_request]) begin
        c6_req_q <= 1'b0;
      end
    end
  end

  // history of comparator-two events between comparator-one falls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      history_q   <= 1'b0;
      comparator_two_seen_q <= 1'b0;
    end else if (drive_en_q && cmp_fall[ppc_pkg::c_one]) begin
      history_q   <= comparator_two_seen_q | comparator_two_ev;
      comparator_two_seen_q <= 1'b0;
    end else if (comparator_two_ev) begin
      comparator_two_seen_q <= 1'b1;
    end
  end

  // ***************************************************
  // control two and timing values
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q       <= ppc_pkg::rst_high_bits;
      c6_ien_q    <= 1'b0;
      gate_q      <= 1'b0;
      src_q       <= 1'b0;
      gain_q      <= ppc_pkg::rst_high_bits;
      start_val_q <= {ppc_pkg::rst_high_bits, ppc_pkg::rst_byte};
      end_a_q     <= {ppc_pkg::rst_high_bits, ppc_pkg::rst_byte};
      end_b_q     <= {ppc_pkg::rst_high_bits, ppc_pkg::rst_byte};
    end else if (wr) begin
      case (idx)
        ppc_pkg::idx_control_two: begin
          ref_q    <= wd[ppc_pkg::pos_comparator_six_ref_hi:ppc_pkg::pos_comparator_six_ref_lo];
          c6_ien_q <= wd[ppc_pkg::pos_comparator_six_irq_enable];
          gate_q   <= wd[ppc_pkg::pos_comparator_seven_gate_enable];
          src_q    <= wd[ppc_pkg::pos_port_thirty_source_select];
          // code three is software's to avoid; stored as written
          gain_q   <= wd[ppc_pkg::pos_amp_two_gain_hi:ppc_pkg::pos_amp_two_gain_lo];
        end
        ppc_pkg::idx_start_low:  start_val_q[7:0] <= wd;
        ppc_pkg::idx_start_high: start_val_q[9:8] <= wd[1:0];
        ppc_pkg::idx_end_a_low:  end_a_q[7:0]     <= wd;
        ppc_pkg::idx_end_a_high: end_a_q[9:8]     <= wd[1:0];
        ppc_pkg::idx_end_b_low:  end_b_q[7:0]     <= wd;
        ppc_pkg::idx_end_b_high: end_b_q[9:8]     <= wd[1:0];
        default: begin
        end
      endcase
    end
  end

  // ***************************************************
  // counter, match buffers and pulse level
  // ***************************************************
  logic [9:0] cnt_q, start_buf_q, end_buf_q;
  logic       level_q;
  logic       start_hit, end_hit;

  assign start_hit = (cnt_q == start_buf_q);
  assign end_hit   = (cnt_q == end_buf_q);

  // sync restarts counter and reloads start buffer
  // end buffer from the selected end set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q       <= 10'h000;
      start_buf_q <= 10'h000;
      end_buf_q   <= 10'h000;
    end else if (sync) begin
      cnt_q       <= 10'h000;
      start_buf_q <= start_val_q;
      end_buf_q   <= sel_q ? end_b_q : end_a_q;
    end else if (run_q && cnt_q != ppc_pkg::cnt_max) begin
      // saturates so a stale period never rematches after wrap
      cnt_q <= cnt_q + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
    end else if (!run_q) begin
      level_q <= 1'b0;
    end else if (!sync) begin
      // end match or comparator three reset
      if (end_hit || cmp_s[ppc_pkg::c_three]) begin
        level_q <= 1'b0;
      // pulse shaped by start and end values
      end else if (start_hit) begin
        level_q <= 1'b1;
      end
    end
  end

  // ***************************************************
  // pins and analog controls, all registered
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_output_pin   <= 1'b0;
      pulse_output_oe_n  <= 1'b1;
      port_thirty_out    <= 1'b0;
      comparator_six_ref <= 2'h0;
      amp_two_gain       <= 2'h0;
      irq_004b           <= 1'b0;
    end else begin
      pulse_output_oe_n  <= ~drive_en_q;
      pulse_output_pin   <= drive_en_q & level_q & ~(gate_q & cmp_s[ppc_pkg::c_seven]);
      port_thirty_out    <= src_q ? cmp_s[ppc_pkg::c_one] : beeper_in;
      comparator_six_ref <= ref_q;
      amp_two_gain       <= gain_q;
      irq_004b           <= (surge_ien_q & surge_flag_q) | (c6_ien_q & c6_req_q);
    end
  end

  // ***************************************************
  // assertions
  // ***************************************************
  sequence s_sync_evt;
    sync;
  endsequence

  sequence s_surge_stop;
    surge_ev && drive_en_q;
  endsequence

  run_low_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    !run_q |=> !level_q ##1 !pulse_output_pin)
    else $error("output high while stopped");

  sync_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_sync_evt |=> (cnt_q == 10'h000) && (start_buf_q == $past(start_val_q)))
    else $error("sync did not restart counter");

  end_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_sync_evt |=> end_buf_q == ($past(sel_q) ? $past(end_b_q) : $past(end_a_q)))
    else $error("end buffer from wrong set");

  start_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_q && !sync && start_hit && !end_hit && !cmp_s[ppc_pkg::c_three] |=> level_q)
    else $error("start match did not set output");

  end_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_q && end_hit && !sync |=> !level_q)
    else $error("end match did not reset output");

  surge_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_surge_stop |=> !run_q && surge_flag_q)
    else $error("surge did not stop run");

  mode_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_q && run_prev_q && $past(run_prev_q) |-> $stable(mode_act_q))
    else $error("active mode changed while running");

  single_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
    run_q && run_prev_q && !mode_act_q |-> !sync)
    else $error("resync in single pulse mode");

  irq_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    surge_ien_q && surge_flag_q |=> irq_004b)
    else $error("surge interrupt missing");

  pin_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
    !drive_en_q |=> pulse_output_oe_n && !pulse_output_pin)
    else $error("pin driven without drive enable");

  gate_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    gate_q && cmp_s[ppc_pkg::c_seven] |=> !pulse_output_pin)
    else $error("gated output went high");

endmodule : ppc_ctrl

/* ppc_pkg.sv */
// shared constants for the programmable pulse generator control block
package ppc_pkg;

  // ***************************************************
  // register indices (byte address is four times the index)
  // ***************************************************
  localparam logic [15:0] idx_control_one    = 16'hfe90;
  localparam logic [15:0] idx_control_two    = 16'hfe91;
  localparam logic [15:0] idx_start_low      = 16'hfe92;
  localparam logic [15:0] idx_start_high     = 16'hfe93;
  localparam logic [15:0] idx_end_a_low      = 16'hfe94;
  localparam logic [15:0] idx_end_a_high     = 16'hfe95;
  localparam logic [15:0] idx_end_b_low      = 16'hfe96;
  localparam logic [15:0] idx_end_b_high     = 16'hfe97;

  // ***************************************************
  // control one field positions
  // ***************************************************
  localparam int pos_pin_drive_enable        = 7;
  localparam int pos_output_run              = 6;
  localparam int pos_resync_mode             = 5;
  localparam int pos_surge_detect_enable     = 4;
  localparam int pos_end_set_select          = 3;
  localparam int pos_comparator_two_history  = 2;
  localparam int pos_surge_flag              = 1;
  localparam int pos_surge_interrupt_enable  = 0;

  // ***************************************************
  // control two field positions
  // ***************************************************
  localparam int pos_comparator_six_ref_hi   = 7;
  localparam int pos_comparator_six_ref_lo   = 6;
  localparam int pos_comparator_six_request  = 5;
  localparam int pos_comparator_six_irq_enable = 4;
  localparam int pos_comparator_seven_gate_enable = 3;
  localparam int pos_port_thirty_source_select = 2;
  localparam int pos_amp_two_gain_hi         = 1;
  localparam int pos_amp_two_gain_lo         = 0;

  // ***************************************************
  // reset values, read fill and widths
  // ***************************************************
  localparam logic [7:0] rst_byte            = 8'h00;
  localparam logic [1:0] rst_high_bits       = 2'h0;
  localparam logic [5:0] high_byte_fill      = 6'h3f;
  localparam int         cnt_w               = 10;
  localparam logic [9:0] cnt_max             = 10'h3ff;
  localparam int         cmp_w               = 8;

  // ***************************************************
  // comparator positions on the synchronised vector
  // ***************************************************
  localparam int c_one   = 0;
  localparam int c_two   = 1;
  localparam int c_three = 2;
  localparam int c_four  = 3;
  localparam int c_five  = 4;
  localparam int c_six   = 5;
  localparam int c_seven = 6;
  localparam int c_eight = 7;

endpackage : ppc_pkg

/* ppc_sync.sv */
// two-flop synchroniser for asynchronous comparator levels
`timescale 1ns/1ps
module ppc_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : ppc_sync

/* ppc_far_model.sv */
// comparator bank, port thirty pad and pulse pin pull-down facing the control block
`timescale 1ns/1ps
module ppc_far_model (
  // clock
  input  wire logic       pclk,
  // block outputs
  input  wire logic       pulse_output_pin,
  input  wire logic       pulse_output_oe_n,
  input  wire logic       port_thirty_out,
  // comparator levels and pad levels
  output logic      [7:0] cmp,
  output logic            pin_level,
  output logic            port_pin
);
  logic port_thirty_latch;
  logic port_thirty_direction;

  initial begin
    cmp = 8'h01;
    port_thirty_latch = 1'b0;
    port_thirty_direction = 1'b1;
  end

  // a released pulse pin sits at its pull-down, never at the last driven level
  assign pin_level = pulse_output_oe_n ? 1'b0 : pulse_output_pin;
  // pad driven only when set up
  assign port_pin = (port_thirty_direction && !port_thirty_latch) ? port_thirty_out : 1'b1;

  // level change after d idle cycles, so the bank can answer promptly or slowly
  task automatic lv(input int i, input logic v, input int d);
    repeat (d + 1) @(posedge pclk);
    cmp[i] <= v;
  endtask : lv
endmodule : ppc_far_model

/* tb_programmable_pulse_generator_ctrl.sv */
// self-checking bench for the pulse generator control block
`timescale 1ns/1ps
module tb_programmable_pulse_generator_ctrl;
  // ***************************************************
  // signals and register table
  // ***************************************************
  localparam logic [15:0] c1a = ppc_pkg::idx_control_one;
  localparam logic [15:0] c2a = ppc_pkg::idx_control_two;
  localparam logic [39:0] rows [9] = '{{c1a, 24'h000000}, {c2a, 24'h009595}, {c2a, 24'h954a4a},
    {c2a, 24'h4ac0c0}, {ppc_pkg::idx_start_low, 24'h000303}, {ppc_pkg::idx_start_high, 24'hfcfcfc},
    {ppc_pkg::idx_end_a_low, 24'h000a0a}, {ppc_pkg::idx_end_a_high, 24'hfc00fc},
    {ppc_pkg::idx_end_b_low, 24'h001414}};
  logic        pclk, presetn, psel, penable, pwrite, beeper_in, er;
  logic [31:0] paddr, pwdata, prdata;
  logic        pready, pslverr, pulse_output_pin, pulse_output_oe_n, port_thirty_out, irq_004b;
  logic [1:0]  comparator_six_ref, amp_two_gain;
  logic [7:0]  cmp, rd, c2v;
  logic        pin_level, port_pin;
  int          error_cnt, checked, cyc_n, d1, d2, w;

  ppc_ctrl ppc_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .comparator_one(cmp[0]), .comparator_two(cmp[1]), .comparator_three(cmp[2]),
    .comparator_four(cmp[3]), .comparator_five(cmp[4]), .comparator_six(cmp[5]),
    .comparator_seven(cmp[6]), .comparator_eight(cmp[7]), .beeper_in, .pulse_output_pin,
    .pulse_output_oe_n, .port_thirty_out, .comparator_six_ref, .amp_two_gain, .irq_004b);
  ppc_far_model ppc_far_model_i (.pclk, .pulse_output_pin, .pulse_output_oe_n, .port_thirty_out,
    .cmp, .pin_level, .port_pin);

  // ***************************************************
  // tasks
  // ***************************************************
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check_val

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {14'h0000, idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check_val({er, rd}, {1'b0, exp});
  endtask : rdchk

  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (pin_level !== v && n < 600) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_lvl

  task automatic quiet(input int n, output int hi);
    hi = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pin_level === 1'b1) hi++;
    end
  endtask : quiet

  task automatic print_verdict();
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // hang guard, far above the several hundred cycles the run needs
  always @(posedge pclk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    {presetn, psel, penable, pwrite, beeper_in, paddr, pwdata} = '0;
    c2v = 8'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_val(pulse_output_oe_n, 1);
    foreach (rows[k]) begin
      rdchk(rows[k][39:24], rows[k][23:16]);
      apb(1'b1, rows[k][39:24], rows[k][15:8]);
      // analog codes follow the last control two write, not the row being written
      if (rows[k][39:24] == c2a) begin
        c2v = rows[k][15:8];
      end
      rdchk(rows[k][39:24], rows[k][7:0]);
      check_val(comparator_six_ref, c2v[7:6]);
      check_val(amp_two_gain, c2v[1:0]);
    end
    apb(1'b1, ppc_pkg::idx_end_b_high, 8'h01);
    rdchk(ppc_pkg::idx_end_b_high, 8'hfd);
    apb(1'b0, 16'hfe98, 8'h00);
    check_val({er, rd}, 9'h100);
    apb(1'b1, c1a, 8'hc0);
    wait_lvl(1'b1, d1);
    wait_lvl(1'b0, w);
    check_val(w, 7);
    ppc_far_model_i.lv(0, 1'b0, 0);
    quiet(40, w);
    check_val(w, 0);
    ppc_far_model_i.lv(0, 1'b1, 0);
    apb(1'b1, c1a, 8'h80);
    apb(1'b1, ppc_pkg::idx_start_low, 8'h08);
    apb(1'b1, c1a, 8'hc8);
    wait_lvl(1'b1, d2);
    wait_lvl(1'b0, w);
    check_val(d2 - d1, 5);
    check_val(w, 268);
    apb(1'b1, ppc_pkg::idx_start_low, 8'h03);
    apb(1'b1, c1a, 8'h80);
    apb(1'b1, c1a, 8'he0);
    wait_lvl(1'b1, d1);
    wait_lvl(1'b0, w);
    check_val(w, 7);
    apb(1'b1, c1a, 8'hc0);
    ppc_far_model_i.lv(0, 1'b0, 2);
    wait_lvl(1'b1, d1);
    wait_lvl(1'b0, w);
    check_val(w, 7);
    ppc_far_model_i.lv(0, 1'b1, 0);
    apb(1'b1, c2a, 8'hc8);
    ppc_far_model_i.lv(6, 1'b1, 0);
    ppc_far_model_i.lv(0, 1'b0, 0);
    quiet(40, w);
    check_val(w, 0);
    ppc_far_model_i.lv(0, 1'b1, 0);
    ppc_far_model_i.lv(6, 1'b0, 0);
    beeper_in <= 1'b1;
    apb(1'b1, c2a, 8'hc4);
    ppc_far_model_i.lv(0, 1'b0, 5);
    repeat (5) @(posedge pclk);
    check_val(port_pin, 0);
    ppc_far_model_i.lv(0, 1'b1, 0);
    apb(1'b1, c2a, 8'hc0);
    beeper_in <= 1'b0;
    repeat (2) @(posedge pclk);
    check_val(port_pin, 0);
    apb(1'b1, c1a, 8'h80);
    apb(1'b1, ppc_pkg::idx_end_a_low, 8'h64);
    apb(1'b1, c1a, 8'hd1);
    wait_lvl(1'b1, d1);
    ppc_far_model_i.lv(3, 1'b1, 0);
    repeat (12) @(posedge pclk);
    check_val(pulse_output_pin, 0);
    rdchk(c1a, 8'h93);
    check_val(irq_004b, 1);
    apb(1'b1, c1a, 8'h91);
    rdchk(c1a, 8'h91);
    check_val(irq_004b, 0);
    ppc_far_model_i.lv(3, 1'b0, 0);
    apb(1'b1, c1a, 8'h80);
    ppc_far_model_i.lv(5, 1'b1, 0);
    apb(1'b1, c2a, 8'h10);
    ppc_far_model_i.lv(5, 1'b0, 0);
    repeat (6) @(posedge pclk);
    rdchk(c2a, 8'h30);
    check_val(irq_004b, 1);
    rdchk(c1a, 8'h80);
    apb(1'b1, c2a, 8'h10);
    rdchk(c2a, 8'h10);
    check_val(irq_004b, 0);
    ppc_far_model_i.lv(1, 1'b1, 0);
    repeat (6) @(posedge pclk);
    rdchk(c1a, 8'h88);
    ppc_far_model_i.lv(0, 1'b0, 0);
    repeat (6) @(posedge pclk);
    rdchk(c1a, 8'h8c);
    ppc_far_model_i.lv(0, 1'b1, 0);
    ppc_far_model_i.lv(0, 1'b0, 3);
    repeat (6) @(posedge pclk);
    rdchk(c1a, 8'h88);
    // comparator three cuts a running pulse
    apb(1'b1, c1a, 8'hc0);
    wait_lvl(1'b1, d1);
    ppc_far_model_i.lv(2, 1'b1, 0);
    wait_lvl(1'b0, w);
    check_val(w, 5);
    ppc_far_model_i.lv(2, 1'b0, 0);
    print_verdict();
  end
endmodule : tb_programmable_pulse_generator_ctrl
